// [shared/lsx_pkg.sv]
package lsx_pkg;

	// ==========================================
	// microword layout
	localparam int MW_W            = 35;
	localparam int MW_OP_HI        = 7;
	localparam int MW_OP_LO        = 5;
	localparam int MW_READ_BIT     = 23;
	localparam int MW_REGULAR_BIT  = 22;
	localparam int MW_SRC_HI       = 25;
	localparam int MW_SRC_LO       = 24;
	localparam int MW_DIRECT_HI    = 23;
	localparam int MW_DIRECT_LO    = 16;
	localparam int MW_SEG_HI       = 19;
	localparam int MW_SEG_LO       = 16;
	localparam int MW_SLOT_HI      = 17;
	localparam int MW_SLOT_LO      = 16;
	localparam int MW_RSEL_HI      = 21;
	localparam int MW_RSEL_LO      = 19;
	localparam int MW_MUXSEL_HI    = 18;
	localparam int MW_MUXSEL_LO    = 17;
	localparam int MW_HALF_BIT     = 18;
	localparam int MW_LIT_A_HI     = 18;
	localparam int MW_LIT_A_LO     = 16;
	localparam int MW_LIT_B_HI     = 11;
	localparam int MW_LIT_B_LO     = 8;
	localparam int MW_LIT_C        = 0;
	localparam int SW_SEL_HI       = 2;

	// ==========================================
	// operation codes and selections
	localparam logic [2:0] OP_STORE_WRITE = 3'h4;
	localparam logic [2:0] OP_TX_LOW      = 3'h2;
	localparam logic [2:0] OP_TX_HIGH     = 3'h3;
	localparam logic [2:0] OP_DISCRETE    = 3'h5;
	localparam logic [1:0] SRC_INDIRECT_A = 2'h0;
	localparam logic [1:0] SRC_INDIRECT_B = 2'h1;
	localparam logic [1:0] SRC_PROCESS    = 2'h2;
	localparam logic [1:0] SRC_DIRECT     = 2'h3;
	// tx slots: 0 initiator tx data, 1 interrupt vector, 2 unused, 3 target tx data
	localparam int STORE_DEPTH    = 1024;
	localparam int ADDR_W         = 10;
	localparam int TX_SLOTS       = 4;
	localparam int MUX_PINS       = 4;
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [9:0]  RST_ADDR = 10'h000;

	typedef enum logic [1:0] {PH_FIRST, PH_MID_EARLY, PH_MID_LATE, PH_LAST} phase_t;

	typedef struct packed {
		logic target_rx_high_enable;
		logic target_rx_low_enable;
		logic initiator_rx_high_enable;
		logic initiator_rx_low_enable;
		logic mux_byte_enable;
		logic slow_read_enable;
		logic parallel_rx_enable;
		logic literal_enable;
	} read_enables_t;

endpackage

// [hw/local_store_ext_reg_access.sv]
`timescale 1ns/1ns
module local_store_ext_reg_access
	import lsx_pkg::*;
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_n,
	input  wire logic [MW_W-1:0]            i_microword_field,
	input  wire logic [7:0]                 i_indirect_pointer,
	input  wire logic [3:0]                 i_process_segment_reg,
	input  wire logic [7:0]                 i_alu_bus,
	input  wire logic [7:0]                 i_target_rx_high,
	input  wire logic [7:0]                 i_target_rx_low,
	input  wire logic [7:0]                 i_initiator_rx_high,
	input  wire logic [7:0]                 i_initiator_rx_low,
	input  wire logic [7:0]                 i_slow_read_data,
	input  wire logic [15:0]                i_parallel_rx_word,
	input  wire logic [MUX_PINS-1:0][7:0]   i_mux_pins,
	input  wire logic [7:0]                 i_addr_switches,
	output logic      [1:0]                 o_phase,
	output logic      [7:0]                 o_bus_data,
	output logic                            o_bus_drive,
	output read_enables_t                   o_read_enables,
	output logic      [ADDR_W-1:0]          o_store_addr,
	output logic                            o_store_ce,
	output logic                            o_store_we,
	output logic                            o_store_write_strobe,
	output logic                            o_tx_slot_low_load,
	output logic                            o_tx_slot_high_load,
	output logic                            o_discrete_access_select,
	output logic                            o_slow_cycle_start,
	output logic      [TX_SLOTS-1:0][15:0]  o_tx_data
);
	default clocking cb_sys @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	// ==========================================
	// decode helpers
	function automatic read_enables_t decode_read(input logic [2:0] sel);
		read_enables_t en;
		en = '0;
		case (sel)
			3'h0: en.target_rx_high_enable = 1'b1;
			3'h1: en.target_rx_low_enable = 1'b1;
			3'h2: en.initiator_rx_high_enable = 1'b1;
			3'h3: en.initiator_rx_low_enable = 1'b1;
			3'h4: en.mux_byte_enable = 1'b1;
			3'h5: en.slow_read_enable = 1'b1;
			3'h6: en.parallel_rx_enable = 1'b1;
			default: en.literal_enable = 1'b1;
		endcase
		return en;
	endfunction

	phase_t                 phase;
	phase_t                 next_phase;
	logic [MW_W-1:0]        mw;
	logic [2:0]             op;
	logic                   ls_write;
	logic                   ls_read;
	logic                   disc;
	logic                   reg_read;
	logic                   slow_start;
	logic                   next_mid;
	logic [7:0]             low_addr;
	logic [ADDR_W-1:0]      next_addr;
	logic [7:0]             store [STORE_DEPTH];
	logic [7:0]             store_rd;
	logic [7:0]             literal;
	logic [7:0]             next_bus_data;
	read_enables_t          sel_en;
	logic [MUX_PINS-1:0][7:0] pins_meta;
	logic [MUX_PINS-1:0][7:0] pins_sync;
	logic [7:0]             sw_meta;
	logic [7:0]             sw_sync;
	logic [7:0]             mux_out;
	logic [7:0]             deskew;

	assign mw = i_microword_field;
	assign op = mw[MW_OP_HI:MW_OP_LO];
	assign ls_write = (op == OP_STORE_WRITE);
	assign ls_read = !mw[MW_OP_HI];
	assign disc = (op == OP_DISCRETE);
	// partial decode: a read ignores the low address bits beyond the select field
	assign reg_read = disc && mw[MW_READ_BIT] && mw[MW_REGULAR_BIT];
	assign slow_start = disc && !mw[MW_REGULAR_BIT];
	assign sel_en = decode_read(mw[MW_RSEL_HI:MW_RSEL_LO]);
	assign literal = {mw[MW_LIT_A_HI:MW_LIT_A_LO], mw[MW_LIT_B_HI:MW_LIT_B_LO],
		mw[MW_LIT_C]};
	assign next_mid = (next_phase == PH_MID_EARLY) || (next_phase == PH_MID_LATE);
	assign o_phase = phase;

	// ==========================================
	// microcycle phases
	always_comb begin
		case (phase)
			PH_FIRST: next_phase = PH_MID_EARLY;
			PH_MID_EARLY: next_phase = PH_MID_LATE;
			PH_MID_LATE: next_phase = PH_LAST;
			PH_LAST: next_phase = PH_FIRST;
			default: next_phase = PH_FIRST;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase <= PH_FIRST;
		end else begin
			phase <= next_phase;
		end
	end

	// ==========================================
	// store addressing
	always_comb begin
		case (mw[MW_SRC_HI:MW_SRC_LO])
			SRC_INDIRECT_A, SRC_INDIRECT_B: low_addr = i_indirect_pointer;
			SRC_PROCESS: low_addr = {i_process_segment_reg, mw[MW_SEG_HI:MW_SEG_LO]};
			default: low_addr = mw[MW_DIRECT_HI:MW_DIRECT_LO];
		endcase
	end
	assign next_addr = {mw[MW_SRC_HI:MW_SRC_LO], low_addr};
	assign store_rd = store[next_addr];

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_store_addr <= RST_ADDR;
			o_store_ce <= 1'b0;
			o_store_we <= 1'b0;
			o_store_write_strobe <= 1'b0;
		end else begin
			o_store_addr <= next_addr;
			o_store_we <= ls_write && next_mid;
			o_store_write_strobe <= ls_write && next_mid;
			o_store_ce <= ls_read || (ls_write && next_mid);
		end
	end

	// ==========================================
	// store array: one write, taken at the close of the middle phase
	always_ff @(posedge i_clk_sys) begin
		if (phase == PH_MID_LATE && ls_write) begin
			store[next_addr] <= i_alu_bus;
		end
	end

	// ==========================================
	// trap loads into the tx slots
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx_data <= {TX_SLOTS{RST_WORD}};
			o_tx_slot_low_load <= 1'b0;
			o_tx_slot_high_load <= 1'b0;
		end else begin
			o_tx_slot_low_load <= (op == OP_TX_LOW) && (next_phase == PH_LAST);
			o_tx_slot_high_load <= (op == OP_TX_HIGH) && (next_phase == PH_LAST);
			if (phase == PH_LAST && op == OP_TX_LOW) begin
				o_tx_data[mw[MW_SLOT_HI:MW_SLOT_LO]][7:0] <= store_rd;
			end
			if (phase == PH_LAST && op == OP_TX_HIGH) begin
				o_tx_data[mw[MW_SLOT_HI:MW_SLOT_LO]][15:8] <= store_rd;
			end
		end
	end

	// ==========================================
	// data multiplexer and deskew register
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pins_meta <= '0;
			pins_sync <= '0;
			sw_meta <= RST_BYTE;
			sw_sync <= RST_BYTE;
		end else begin
			pins_meta <= i_mux_pins;
			pins_sync <= pins_meta;
			sw_meta <= i_addr_switches;
			sw_sync <= sw_meta;
		end
	end

	genvar gb;
	generate
		for (gb = 0; gb < 8; gb++) begin : g_mux
			always_comb begin
				case (mw[MW_MUXSEL_HI:MW_MUXSEL_LO])
					2'h0: begin
						// pin 0 bit 0 carries one switch bit at a time
						if (gb == 0) begin
							mux_out[gb] = sw_sync[i_indirect_pointer[SW_SEL_HI:0]];
						end else begin
							mux_out[gb] = pins_sync[0][gb];
						end
					end
					2'h1: mux_out[gb] = pins_sync[1][gb];
					2'h2: mux_out[gb] = pins_sync[2][gb];
					default: mux_out[gb] = pins_sync[3][gb];
				endcase
			end
		end
	endgenerate

	// latched late, so a byte read now reflects the select of the previous microcycle
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			deskew <= RST_BYTE;
		end else if (phase == PH_LAST) begin
			deskew <= mux_out;
		end
	end

	// ==========================================
	// internal bus
	always_comb begin
		next_bus_data = store_rd;
		if (reg_read) begin
			case (mw[MW_RSEL_HI:MW_RSEL_LO])
				3'h0: next_bus_data = i_target_rx_high;
				3'h1: next_bus_data = i_target_rx_low;
				3'h2: next_bus_data = i_initiator_rx_high;
				3'h3: next_bus_data = i_initiator_rx_low;
				3'h4: next_bus_data = deskew;
				3'h5: next_bus_data = i_slow_read_data;
				3'h6: next_bus_data = mw[MW_HALF_BIT] ? i_parallel_rx_word[7:0]
					: i_parallel_rx_word[15:8];
				default: next_bus_data = literal;
			endcase
		end
	end

	// first phase stays quiet so the last driver has released the bus
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bus_data <= RST_BYTE;
			o_bus_drive <= 1'b0;
			o_read_enables <= '0;
		end else begin
			o_bus_data <= next_bus_data;
			o_bus_drive <= (next_phase != PH_FIRST) && (ls_read || reg_read);
			o_read_enables <= (next_phase != PH_FIRST && reg_read) ? sel_en : '0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_discrete_access_select <= 1'b0;
			o_slow_cycle_start <= 1'b0;
		end else begin
			o_discrete_access_select <= disc;
			o_slow_cycle_start <= slow_start && (phase == PH_FIRST);
		end
	end

	// ==========================================
	// assertions
	property p_write_mid;
		(phase == PH_FIRST && ls_write) |=> (o_store_we && o_store_ce);
	endproperty
	a_write_mid: assert property (p_write_mid) else $error("store write not in middle");
	property p_we_window;
		o_store_we |-> (phase == PH_MID_EARLY || phase == PH_MID_LATE);
	endproperty
	a_we_window: assert property (p_we_window) else $error("write enable outside middle");
	property p_read_ce;
		!i_microword_field[MW_OP_HI] |=> (o_store_ce && !o_store_we);
	endproperty
	a_read_ce: assert property (p_read_ce) else $error("store read enable wrong");
	property p_addr_direct;
		(mw[MW_SRC_HI:MW_SRC_LO] == SRC_DIRECT)
		|=> (o_store_addr == {SRC_DIRECT, $past(mw[MW_DIRECT_HI:MW_DIRECT_LO])});
	endproperty
	a_addr_direct: assert property (p_addr_direct) else $error("direct address wrong");
	property p_addr_process;
		(mw[MW_SRC_HI:MW_SRC_LO] == SRC_PROCESS) |=> (o_store_addr ==
			{SRC_PROCESS, $past(i_process_segment_reg), $past(mw[MW_SEG_HI:MW_SEG_LO])});
	endproperty
	a_addr_process: assert property (p_addr_process) else $error("process address wrong");
	property p_addr_indirect;
		!mw[MW_SRC_HI] |=> (o_store_addr[7:0] == $past(i_indirect_pointer) && !o_store_addr[9]);
	endproperty
	a_addr_indirect: assert property (p_addr_indirect) else $error("indirect address wrong");
	property p_tx_low;
		(phase == PH_LAST && op == OP_TX_LOW)
		|=> (o_tx_data[$past(mw[MW_SLOT_HI:MW_SLOT_LO])][7:0] == $past(store_rd));
	endproperty
	a_tx_low: assert property (p_tx_low) else $error("tx low load wrong");
	property p_tx_high;
		(phase == PH_LAST && op == OP_TX_HIGH)
		|=> (o_tx_data[$past(mw[MW_SLOT_HI:MW_SLOT_LO])][15:8] == $past(store_rd));
	endproperty
	a_tx_high: assert property (p_tx_high) else $error("tx high load wrong");
	property p_first_quiet;
		(phase == PH_FIRST) |-> (o_read_enables == '0 && !o_bus_drive);
	endproperty
	a_first_quiet: assert property (p_first_quiet) else $error("bus driven in first phase");
	property p_literal;
		(reg_read && sel_en.literal_enable && phase != PH_LAST)
		|=> (o_read_enables.literal_enable && o_bus_data == $past(literal));
	endproperty
	a_literal: assert property (p_literal) else $error("literal not on bus");
	property p_deskew;
		(phase == PH_LAST) |=> (deskew == $past(mux_out)) ##1 $stable(deskew) [*3];
	endproperty
	a_deskew: assert property (p_deskew) else $error("deskew register wrong");

	c_write: cover property (o_store_we ##1 o_store_we ##1 !o_store_we);
	c_tx_load: cover property (o_tx_slot_high_load);
	c_mux_read: cover property (o_read_enables.mux_byte_enable);
	c_slow: cover property (o_slow_cycle_start);

endmodule

// [tb/ucode_partner.sv]
`timescale 1ns/1ns
module ucode_partner
	import lsx_pkg::*;
(
	input  wire logic            i_clk_sys,
	input  wire logic [1:0]      i_phase,
	input  wire logic [MW_W-1:0] i_next_mw,
	input  wire logic [7:0]      i_next_alu,
	output logic      [MW_W-1:0] o_microword_field,
	output logic      [7:0]      o_alu_bus
);
	logic [1:0]      seen;
	logic [MW_W-1:0] cur;

	initial begin
		o_microword_field = '0;
		o_alu_bus = 8'h00;
	end

	// ==========================================
	// sequencer and alu side
	// a new microword only at the 3 -> 0 boundary; the bus carries data only in
	// a store write microcycle and churns otherwise, so a stray write is visible
	always @(posedge i_clk_sys) begin
		seen = i_phase;
		#2;
		cur = (seen === 2'h3) ? i_next_mw : o_microword_field;
		o_microword_field <= cur;
		o_alu_bus <= (cur[7:5] === OP_STORE_WRITE) ? i_next_alu : ~o_alu_bus;
	end
endmodule

// [tb/local_store_ext_reg_access_tb_top.sv]
`timescale 1ns/1ns
module local_store_ext_reg_access_tb_top
	import lsx_pkg::*;
;
	logic                     clk;
	logic                     rst_n;
	logic [MW_W-1:0]          mw;
	logic [MW_W-1:0]          next_mw;
	logic [7:0]               next_alu;
	logic [7:0]               alu;
	logic [MUX_PINS-1:0][7:0] pins;
	logic [1:0]               o_phase;
	logic [7:0]               o_bus_data;
	logic                     o_bus_drive;
	read_enables_t            o_read_enables;
	logic [ADDR_W-1:0]        o_store_addr;
	logic                     o_store_ce;
	logic                     o_store_we;
	logic                     o_store_write_strobe;
	logic                     o_tx_slot_low_load;
	logic                     o_tx_slot_high_load;
	logic                     o_discrete_access_select;
	logic                     o_slow_cycle_start;
	logic [TX_SLOTS-1:0][15:0] o_tx_data;
	int                       n_fail;
	int                       num_checks;

	localparam logic [7:0]  PTR = 8'h23;
	localparam logic [15:0] PAR = 16'hc66e;
	localparam logic [7:0]  SW  = 8'ha5;
	logic [7:0]               ptr;
	logic [3:0]               seg;
	logic [7:0]               sw;
	logic [15:0]              par;

	initial begin
		clk = 1'b0;
		n_fail = 0;
		num_checks = 0;
		next_mw = '0;
		next_alu = 8'h00;
		pins = {8'he2, 8'hb8, 8'h71, 8'h3d};
	end
	always #4 clk = ~clk;

	ucode_partner u_partner (.i_clk_sys(clk), .i_phase(o_phase), .i_next_mw(next_mw),
		.i_next_alu(next_alu), .o_microword_field(mw), .o_alu_bus(alu));

	local_store_ext_reg_access dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_microword_field(mw),
		.i_indirect_pointer(ptr), .i_process_segment_reg(seg), .i_alu_bus(alu),
		.i_target_rx_high(8'h81), .i_target_rx_low(8'h42), .i_initiator_rx_high(8'h93),
		.i_initiator_rx_low(8'h24), .i_slow_read_data(8'h57), .i_parallel_rx_word(par),
		.i_mux_pins(pins), .i_addr_switches(sw), .o_phase(o_phase), .o_bus_data(o_bus_data),
		.o_bus_drive(o_bus_drive), .o_read_enables(o_read_enables),
		.o_store_addr(o_store_addr), .o_store_ce(o_store_ce), .o_store_we(o_store_we),
		.o_store_write_strobe(o_store_write_strobe), .o_tx_slot_low_load(o_tx_slot_low_load),
		.o_tx_slot_high_load(o_tx_slot_high_load),
		.o_discrete_access_select(o_discrete_access_select),
		.o_slow_cycle_start(o_slow_cycle_start), .o_tx_data(o_tx_data));

	// ==========================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [MW_W-1:0] mk(input logic [2:0] op, input logic [1:0] src,
		input logic [7:0] hi, input logic [15:0] lo);
		logic [MW_W-1:0] w;
		w = {9'h000, src, hi, lo};
		w[7:5] = op;
		return w;
	endfunction

	task automatic ph();
		@(posedge clk);
		#3;
	endtask

	// leaves the bench in phase 0 of the microcycle running w
	task automatic cyc(input logic [MW_W-1:0] w, input logic [7:0] a);
		int k;
		next_mw = w;
		next_alu = a;
		k = 0;
		ph();
		while (o_phase !== 2'h0 && k < 8) begin
			ph();
			k++;
		end
	endtask

	task automatic t_write(input logic [1:0] src, input logic [7:0] hi, input logic [7:0] d,
		input logic [9:0] addr);
		cyc(mk(OP_STORE_WRITE, src, hi, 16'h0000), d);
		ph();
		chk(16'({o_store_we, o_store_ce, o_store_write_strobe}), 16'h0007);
		chk(16'(o_store_addr), 16'(addr));
		ph();
		chk(16'(o_store_we), 16'h0001);
		ph();
		chk(16'(o_store_we), 16'h0000);
	endtask

	task automatic t_read(input logic [1:0] src, input logic [7:0] hi, input logic [7:0] d);
		cyc(mk(3'h0, src, hi, 16'h0000), 8'h00);
		ph();
		ph();
		chk(16'({o_store_ce, o_store_we}), 16'h0002);
		ph();
		chk(16'({o_bus_drive, o_bus_data}), {7'h00, 1'b1, d});
	endtask

	// ==========================================
	// scenarios
	task automatic t_addr();
		t_write(2'h0, 8'h00, 8'h11, 10'h023);
		t_write(2'h1, 8'h00, 8'h22, 10'h123);
		t_write(2'h2, 8'hf6, 8'h33, 10'h296);
		t_write(2'h3, 8'h5a, 8'h44, 10'h35a);
		t_read(2'h0, 8'h00, 8'h11);
		t_read(2'h1, 8'h00, 8'h22);
		t_read(2'h2, 8'hf6, 8'h33);
		t_read(2'h3, 8'h5a, 8'h44);
		t_read(2'h0, 8'h00, 8'h11);
	endtask

	// the direct address low bits double as the slot code
	task automatic t_tx();
		for (int s = 0; s < 4; s++) begin
			t_write(2'h3, 8'(8'h40 + s), 8'(8'h10 + s), 10'(10'h340 + s));
			t_write(2'h3, 8'(8'h80 + s), 8'(8'hc0 + s), 10'(10'h380 + s));
		end
		for (int s = 0; s < 4; s++) begin
			cyc(mk(OP_TX_LOW, 2'h3, 8'(8'h40 + s), 16'h0000), 8'h00);
			ph();
			ph();
			ph();
			chk(16'({o_tx_slot_low_load, o_store_ce}), 16'h0003);
			cyc(mk(OP_TX_HIGH, 2'h3, 8'(8'h80 + s), 16'h0000), 8'h00);
			ph();
			ph();
			ph();
			chk(16'({o_tx_slot_high_load, o_tx_slot_low_load}), 16'h0002);
		end
		cyc(mk(3'h0, 2'h0, 8'h00, 16'h0000), 8'h00);
		for (int s = 0; s < 4; s++) begin
			chk(o_tx_data[s], {8'(8'hc0 + s), 8'(8'h10 + s)});
		end
	endtask

	task automatic t_disc(input logic [2:0] low3);
		logic [7:0] ex [8];
		ex[0] = 8'h81;
		ex[1] = 8'h42;
		ex[2] = 8'h93;
		ex[3] = 8'h24;
		ex[4] = pins[low3[2:1]];
		ex[5] = 8'h57;
		ex[6] = low3[2] ? par[7:0] : par[15:8];
		ex[7] = {low3, 4'ha, 1'b1};
		if (low3[2:1] == 2'h0) begin
			ex[4][0] = sw[ptr[2:0]];
		end
		for (int sel = 0; sel < 8; sel++) begin
			cyc(mk(OP_DISCRETE, 2'h0, {2'b11, 3'(sel), low3}, 16'h0a01), 8'h00);
			chk(16'({o_read_enables, o_bus_drive}), 16'h0000);
			ph();
			chk(16'({o_discrete_access_select, o_slow_cycle_start}), 16'h0002);
			chk(16'(o_read_enables), 16'(8'h80 >> sel));
			ph();
			ph();
			chk(16'({o_bus_drive, o_bus_data}), {7'h00, 1'b1, ex[sel]});
		end
	endtask

	// select is set one microcycle ahead of each deskew read
	task automatic t_pipe();
		cyc(mk(3'h0, 2'h0, 8'h02, 16'h0000), 8'h00);
		cyc(mk(OP_DISCRETE, 2'h0, 8'he6, 16'h0000), 8'h00);
		ph();
		ph();
		ph();
		chk(16'(o_bus_data), 16'(pins[1]));
		cyc(mk(OP_DISCRETE, 2'h0, 8'he0, 16'h0000), 8'h00);
		ph();
		ph();
		ph();
		chk(16'(o_bus_data), 16'(pins[3]));
	endtask

	task automatic t_slow();
		cyc(mk(OP_DISCRETE, 2'h0, 8'h88, 16'h0000), 8'h00);
		ph();
		chk(16'({o_slow_cycle_start, o_read_enables}), 16'h0100);
		ph();
		chk(16'(o_slow_cycle_start), 16'h0000);
	endtask

	// a new pointer must steer a different switch bit into pin 0 bit 0
	task automatic t_switch();
		@(posedge clk);
		#2;
		ptr = 8'h25;
		t_disc(3'b001);
	endtask

	// ==========================================
	// run control
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#50000;
		n_fail++;
		give_verdict();
	end

	initial begin
		rst_n = 1'b0;
		ptr = PTR;
		seg = 4'h9;
		sw = SW;
		par = PAR;
		repeat (6) @(posedge clk);
		#3;
		chk(16'({o_phase, o_read_enables, o_store_we}), 16'h0000);
		repeat (6) @(posedge clk);
		#2;
		rst_n = 1'b1;
		t_addr();
		t_tx();
		t_disc(3'b101);
		t_disc(3'b001);
		t_switch();
		t_pipe();
		t_slow();
		give_verdict();
	end
endmodule
